// ### rtl/pllc_ahb_front.sv
// Purpose: AHB-Lite address phase capture for the PLL lock block.
// Assumes: Single slave, so hready_in is this slave's own hreadyout.
// Notes: Reads take one wait state so a read always sees a prior write.
`timescale 1ns/1ps
`default_nettype none
module pllc_ahb_front
    import pllc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    output pllc_req_t req_out,
    output logic wr_stb_out,
    output logic rd_stb_out,
    output logic hreadyout_out
);
    logic wr_q;
    logic rd_q;
    wire accept = hsel_in && (htrans_in == PLLC_HTRANS_NONSEQ) && hready_in;
    // Only lane 0 carries the 8-bit registers; narrower writes elsewhere are dropped.
    wire lane0 = (hsize_in == PLLC_HSIZE_WORD)
        || ((hsize_in == PLLC_HSIZE_HALF) && !haddr_in[1])
        || ((hsize_in == PLLC_HSIZE_BYTE) && (haddr_in[1:0] == 2'h0));

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout_out <= 1'b1;
            req_out <= '0;
        end else begin
            wr_q <= accept && hwrite_in;
            rd_q <= accept && !hwrite_in;
            hreadyout_out <= !(accept && !hwrite_in);
            if (accept) begin
                req_out <= '{addr: haddr_in, write: hwrite_in, lane0: lane0};
            end
        end
    end

    assign wr_stb_out = wr_q && req_out.lane0;
    assign rd_stb_out = rd_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_read_wait_one: assert property (@(posedge mclk_in) disable iff (rst_in)
        (accept && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read did not take exactly one wait state");
endmodule
`default_nettype wire

// ### rtl/pllc_lockup_timer.sv
// Purpose: Counts the selected lockup interval in main oscillator cycles.
// Assumes: run_in stays high from the start of the interval until expiry.
// Notes: Dropping run_in discards the partial count.
`timescale 1ns/1ps
`default_nettype none
module pllc_lockup_timer
    import pllc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = PLLC_LOCKUP_BASE
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [PLLC_SEL_W-1:0] sel_in,
    output logic expired_out
);
    logic [PLLC_CNT_W-1:0] cnt_q;
    wire [PLLC_CNT_W-1:0] target = PLLC_CNT_W'(BASE_CYCLES) << sel_in;
    wire [PLLC_CNT_W-1:0] target_m1 = target - PLLC_CNT_W'(1);

    always_ff @(posedge mclk_in) begin
        if (rst_in || !run_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + PLLC_CNT_W'(1);
        end
    end

    assign expired_out = run_in && (cnt_q == target_m1);

    a_count_bound: assert property (@(posedge mclk_in) disable iff (rst_in)
        run_in |-> cnt_q <= target_m1)
        else $error("lockup counter ran past its target");
endmodule
`default_nettype wire

// ### rtl/pllc_pkg.sv
// Purpose: Shared constants and types for the PLL lock supervision block.
// Assumes: The main oscillator clock is the block clock; 8-bit registers sit in word lanes.
// Notes: Register offsets are full AHB byte addresses.
package pllc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [31:0] PLLC_ADDR_LOCK = 32'hfffff824;
    localparam logic [31:0] PLLC_ADDR_LOCKUP_SEL = 32'hfffff828;
    localparam logic [31:0] PLLC_ADDR_CONTROL = 32'hfffff82c;
    localparam logic [31:0] PLLC_ADDR_PCC = 32'hfffff830;

    localparam logic [7:0] PLLC_LOCK_RST = 8'h01;
    localparam logic [7:0] PLLC_SEL_RST = 8'h03;
    localparam logic [7:0] PLLC_CTRL_RST = 8'h01;
    localparam logic [7:0] PLLC_PCC_RST = 8'h00;

    localparam int PLLC_BIT_ENABLE = 0;
    localparam int PLLC_BIT_CLKSEL = 1;
    localparam int PLLC_BIT_SUBCLK = 0;
    localparam int PLLC_BIT_MCKSTOP = 1;
    localparam int PLLC_SEL_W = 2;
    localparam int PLLC_REG_W = 8;

    // ----------------------------------------------------------------
    // Bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] PLLC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PLLC_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] PLLC_HSIZE_HALF = 3'h1;
    localparam logic [2:0] PLLC_HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Lockup timing
    // ----------------------------------------------------------------
    localparam int PLLC_CNT_W = 14;
    localparam int PLLC_LOCKUP_BASE = 1024;

    typedef enum logic [2:0] {
        PLLC_ST_OSC_WAIT = 3'b000,
        PLLC_ST_OFF = 3'b001,
        PLLC_ST_COUNT = 3'b010,
        PLLC_ST_LOCKED = 3'b011,
        PLLC_ST_SUBCLK = 3'b100,
        PLLC_ST_STANDBY = 3'b101
    } pllc_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic lane0;
    } pllc_req_t;

endpackage

// ### rtl/pllc_top.sv
// Purpose: PLL lock supervision with control, lockup select and lock status registers.
// Assumes: Standby requests and the oscillation-settled pulse come from logic on mclk_in.
// Notes: The PLL run and clock select outputs are the effective controls, not raw bits.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - lock flag zero locked, one unlocked
// - lock status register is read-only byte
// - reset sets flag, cleared after oscillation settles
// - deep idle or stop sets unlocked
// - clearing PLL enable sets unlocked
// - subclock plus main stop sets unlocked
// - enable rising times lockup, then locked
// - lockup select picks 2^10..2^13, reset three
// - after reset enable one, select zero
// - standby stops PLL, exit restores state
// - light idle keeps PLL running
// - clock select one accepted only when locked
// - control resets to 01, two bits used
module pllc_top
    import pllc_pkg::*;
#(
    parameter int unsigned LOCKUP_BASE_CYCLES = PLLC_LOCKUP_BASE
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic deep_idle_in,
    input wire logic stop_mode_in,
    input wire logic osc_stab_done_in,
    output logic pll_run_out,
    output logic pll_clk_sel_out,
    output logic pll_unlocked_out
);

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    pllc_req_t req;
    logic wr_stb;
    logic rd_stb;

    pllc_ahb_front u_front (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hsize_in(hsize_in),
        .hready_in(hready_in),
        .req_out(req),
        .wr_stb_out(wr_stb),
        .rd_stb_out(rd_stb),
        .hreadyout_out(hreadyout_out)
    );

    // ----------------------------------------------------------------
    // Registers and decode
    // ----------------------------------------------------------------
    logic enable_q;
    logic clksel_q;
    logic [PLLC_SEL_W-1:0] sel_q;
    logic subclk_q;
    logic mckstop_q;
    logic [31:0] hrdata_q;
    logic hresp_q;
    pllc_state_t state_q;
    pllc_state_t state_d;
    logic expired;

    wire hit_lock = (req.addr == PLLC_ADDR_LOCK);
    wire hit_sel = (req.addr == PLLC_ADDR_LOCKUP_SEL);
    wire hit_ctrl = (req.addr == PLLC_ADDR_CONTROL);
    wire hit_pcc = (req.addr == PLLC_ADDR_PCC);
    wire wr_sel = wr_stb && hit_sel;
    wire wr_ctrl = wr_stb && hit_ctrl;
    wire wr_pcc = wr_stb && hit_pcc;
    wire [7:0] wbyte = hwdata_in[PLLC_REG_W-1:0];
    wire is_locked = (state_q == PLLC_ST_LOCKED);
    // only deep idle and stop count as standby
    wire standby = deep_idle_in || stop_mode_in;
    wire main_stop = subclk_q && mckstop_q;

    wire [7:0] rd_lock = {7'h00, pll_unlocked_out};
    wire [7:0] rd_sel = {6'h00, sel_q};
    wire [7:0] rd_ctrl = {6'h00, clksel_q, enable_q};
    wire [7:0] rd_pcc = {6'h00, mckstop_q, subclk_q};
    // Unmapped addresses read zero and still answer OKAY.
    wire [7:0] rd_byte = hit_lock ? rd_lock :
        hit_sel ? rd_sel :
        hit_ctrl ? rd_ctrl :
        hit_pcc ? rd_pcc : 8'h00;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            enable_q <= PLLC_CTRL_RST[PLLC_BIT_ENABLE];
            clksel_q <= PLLC_CTRL_RST[PLLC_BIT_CLKSEL];
        end else if (wr_ctrl) begin
            enable_q <= wbyte[PLLC_BIT_ENABLE];
            clksel_q <= wbyte[PLLC_BIT_CLKSEL] && is_locked;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sel_q <= PLLC_SEL_RST[PLLC_SEL_W-1:0];
        end else if (wr_sel) begin
            sel_q <= wbyte[PLLC_SEL_W-1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            subclk_q <= PLLC_PCC_RST[PLLC_BIT_SUBCLK];
            mckstop_q <= PLLC_PCC_RST[PLLC_BIT_MCKSTOP];
        end else if (wr_pcc) begin
            subclk_q <= wbyte[PLLC_BIT_SUBCLK];
            mckstop_q <= wbyte[PLLC_BIT_MCKSTOP];
        end
    end

    // lock status has no write path
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hrdata_q <= '0;
            hresp_q <= 1'b0;
        end else if (rd_stb) begin
            hrdata_q <= {24'h000000, rd_byte};
        end
    end

    // ----------------------------------------------------------------
    // Lock supervision
    // ----------------------------------------------------------------
    pllc_lockup_timer #(
        .BASE_CYCLES(LOCKUP_BASE_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .run_in(state_q == PLLC_ST_COUNT),
        .sel_in(sel_q),
        .expired_out(expired)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PLLC_ST_OSC_WAIT: begin
                if (osc_stab_done_in) begin
                    state_d = enable_q ? PLLC_ST_LOCKED : PLLC_ST_OFF;
                end
            end
            PLLC_ST_OFF: begin
                if (enable_q) begin
                    state_d = PLLC_ST_COUNT;
                end
            end
            PLLC_ST_COUNT: begin
                if (expired) begin
                    state_d = PLLC_ST_LOCKED;
                end
            end
            PLLC_ST_LOCKED: begin
                state_d = PLLC_ST_LOCKED;
            end
            PLLC_ST_SUBCLK: begin
                if (!main_stop) begin
                    state_d = enable_q ? PLLC_ST_COUNT : PLLC_ST_OFF;
                end
            end
            PLLC_ST_STANDBY: begin
                if (!standby) begin
                    state_d = PLLC_ST_OSC_WAIT;
                end
            end
            default: begin
                state_d = PLLC_ST_OSC_WAIT;
            end
        endcase
        if (standby) begin
            state_d = PLLC_ST_STANDBY;
        end else if (main_stop && state_q != PLLC_ST_STANDBY) begin
            state_d = PLLC_ST_SUBCLK;
        end else if (!enable_q && (state_q == PLLC_ST_COUNT || state_q == PLLC_ST_LOCKED)) begin
            state_d = PLLC_ST_OFF;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= PLLC_ST_OSC_WAIT;
            pll_unlocked_out <= PLLC_LOCK_RST[0];
            pll_run_out <= 1'b0;
            pll_clk_sel_out <= 1'b0;
        end else begin
            state_q <= state_d;
            pll_unlocked_out <= (state_d != PLLC_ST_LOCKED);
            pll_run_out <= enable_q && (state_d != PLLC_ST_STANDBY)
                && (state_d != PLLC_ST_SUBCLK);
            pll_clk_sel_out <= clksel_q && (state_d == PLLC_ST_LOCKED);
        end
    end

    assign hrdata_out = hrdata_q;
    assign hresp_out = hresp_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    logic [PLLC_CNT_W-1:0] hlp_cnt_q;
    wire [PLLC_CNT_W-1:0] hlp_target = PLLC_CNT_W'(LOCKUP_BASE_CYCLES) << sel_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in || state_q != PLLC_ST_COUNT) begin
            hlp_cnt_q <= '0;
        end else begin
            hlp_cnt_q <= hlp_cnt_q + PLLC_CNT_W'(1);
        end
    end

    a_lockup_length: assert property (
        (state_q == PLLC_ST_COUNT && state_d == PLLC_ST_LOCKED)
        |-> hlp_cnt_q == hlp_target - PLLC_CNT_W'(1))
        else $error("lockup interval length wrong");

    a_standby_unlock: assert property (
        standby |=> pll_unlocked_out && !pll_run_out && !pll_clk_sel_out)
        else $error("standby did not unlock and stop the PLL");

    a_disable_unlock: assert property (
        (wr_ctrl && !wbyte[PLLC_BIT_ENABLE] && !standby && !main_stop)
        |=> ##1 pll_unlocked_out)
        else $error("clearing enable did not unlock");

    a_subclk_unlock: assert property (
        (wr_pcc && wbyte[PLLC_BIT_SUBCLK] && wbyte[PLLC_BIT_MCKSTOP])
        |=> ##1 pll_unlocked_out && state_q != PLLC_ST_LOCKED)
        else $error("subclock with main stop did not unlock");

    a_select_guard: assert property (
        (wr_ctrl && !is_locked) |=> !clksel_q)
        else $error("clock select accepted while unlocked");

    a_reset_values: assert property (
        $past(rst_in) |-> pll_unlocked_out && enable_q && !clksel_q
        && sel_q == PLLC_SEL_RST[PLLC_SEL_W-1:0])
        else $error("reset values wrong");

    a_restart_count: assert property (
        (state_q == PLLC_ST_COUNT && !enable_q && !standby && !main_stop)
        |=> state_q == PLLC_ST_OFF ##1 hlp_cnt_q == '0)
        else $error("aborted lockup count not discarded");

    a_settle_clear: assert property (
        (state_q == PLLC_ST_OSC_WAIT && osc_stab_done_in && enable_q && !standby && !main_stop)
        |=> !pll_unlocked_out)
        else $error("flag not cleared after oscillation settled");

    a_bus_okay: assert property (
        !hresp_out)
        else $error("bus response not OKAY");
endmodule
`default_nettype wire

// ### tb/pllc_testbench.sv
// Purpose: Self-checking bench for the PLL lock supervision block.
// Assumes: Lockup base shortened to 8 cycles; standby and settle inputs come from here.
// Notes: An integer model tracks the registers; reads are compared with it.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pllc_pkg::*;
();
    localparam int BASE = 8;
    localparam int BOUND = 400;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel, hwrite, deep_idle, stop_mode, osc_done;
    logic hready, hresp, pll_run, clk_sel, unlocked;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] lfsr_q;
    int n_errors, checks_done, m_ctrl, m_sel, m_pcc, m_unl, cyc;

    always #5 mclk_in = ~mclk_in;

    pllc_top #(.LOCKUP_BASE_CYCLES(BASE)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .deep_idle_in(deep_idle), .stop_mode_in(stop_mode),
        .osc_stab_done_in(osc_done), .pll_run_out(pll_run), .pll_clk_sel_out(clk_sel),
        .pll_unlocked_out(unlocked)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic timed_out(input string nm);
        n_errors++;
        $display("ERROR %s expected done seen timeout", nm);
        end_of_test();
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // ----------------------------------------------------------------
    // Bus master and model
    // ----------------------------------------------------------------
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge mclk_in);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            timed_out("hready");
        end
    endtask

    // Called just after an edge; returns just after the edge that ends the data phase.
    // every access is one whole aligned word.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= PLLC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= PLLC_HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rdata = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        if (a == PLLC_ADDR_LOCKUP_SEL) begin
            m_sel = d & 3;
        end
        if (a == PLLC_ADDR_CONTROL) begin
            m_ctrl = d[0] | ((d[1] & (m_unl == 0)) << 1);
            if (!d[0]) begin
                m_unl = 1;
            end
        end
        if (a == PLLC_ADDR_PCC) begin
            m_pcc = d & 3;
            if (m_pcc == 3) begin
                m_unl = 1;
            end
        end
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input int exp, input string nm);
        bus(1'b0, a, 32'h0);
        check(nm, rdata, exp);
    endtask

    task automatic wait_flag(input logic v);
        cyc = 0;
        while (unlocked !== v && cyc < BOUND) begin
            @(posedge mclk_in);
            cyc++;
        end
        if (cyc >= BOUND) begin
            timed_out("lock flag");
        end
    endtask

    // the pulse stands for the programmed settle time.
    task automatic settle();
        osc_done <= 1'b1;
        @(posedge mclk_in);
        osc_done <= 1'b0;
        wait_flag(1'b0);
        m_unl = 0;
    endtask

    // The window allows for the register and state stages ahead of the count.
    task automatic relock(input string nm);
        int n;
        n = BASE << m_sel;
        wait_flag(1'b0);
        check(nm, {31'h0, cyc >= n && cyc <= n + 3}, 32'h1);
        m_unl = 0;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = PLLC_HSIZE_WORD;
        deep_idle = 1'b0;
        stop_mode = 1'b0;
        osc_done = 1'b0;
        n_errors = 0;
        checks_done = 0;
        m_ctrl = 1;
        m_sel = 3;
        m_pcc = 0;
        m_unl = 1;
        lfsr_q = 8'h06;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        check("flag at reset", {31'h0, unlocked}, 32'h1);
        rd(PLLC_ADDR_LOCK, m_unl, "lock reset");
        rd(PLLC_ADDR_LOCKUP_SEL, m_sel, "select reset");
        rd(PLLC_ADDR_CONTROL, m_ctrl, "control reset");
        rd(PLLC_ADDR_PCC, m_pcc, "pcc reset");
        check("pll run", {31'h0, pll_run}, 32'h1);
        wr(PLLC_ADDR_LOCK, 32'hff);
        rd(PLLC_ADDR_LOCK, m_unl, "lock write");
        wr(32'hfffff900, 32'h5a);
        rd(32'hfffff900, 0, "unmapped");
        wr(PLLC_ADDR_CONTROL, 32'h3);
        rd(PLLC_ADDR_CONTROL, m_ctrl, "select unlocked");
        check("clk sel unlocked", {31'h0, clk_sel}, 32'h0);
        settle();
        check("settle time", {31'h0, cyc <= 3}, 32'h1);
        rd(PLLC_ADDR_LOCK, m_unl, "lock settled");
        // select only after the lock flag reads zero.
        wr(PLLC_ADDR_CONTROL, 32'h3);
        tick2();
        check("clk sel locked", {31'h0, clk_sel}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(PLLC_ADDR_LOCKUP_SEL, {24'h0, lfsr_q[7:2], 2'(i)});
            rd(PLLC_ADDR_LOCKUP_SEL, m_sel, "select field");
            wr(PLLC_ADDR_CONTROL, 32'h1);
            repeat (8) @(posedge mclk_in);
            // an unused PLL is switched off.
            wr(PLLC_ADDR_CONTROL, 32'h0);
            wait_flag(1'b1);
            check("disable flag", {31'h0, cyc <= 3}, 32'h1);
            rd(PLLC_ADDR_CONTROL, m_ctrl, "control off");
            wr(PLLC_ADDR_CONTROL, 32'h1);
            relock("lockup time");
        end
        wr(PLLC_ADDR_CONTROL, 32'h0);
        wait_flag(1'b1);
        wr(PLLC_ADDR_CONTROL, 32'h1);
        repeat (40) @(posedge mclk_in);
        wr(PLLC_ADDR_CONTROL, 32'h0);
        wr(PLLC_ADDR_CONTROL, 32'h1);
        relock("restarted lockup");
        wr(PLLC_ADDR_CONTROL, 32'h3);
        for (int m = 1; m < 3; m++) begin
            deep_idle <= m[0];
            stop_mode <= m[1];
            tick2();
            check("standby flag", {31'h0, unlocked}, 32'h1);
            check("standby run", {31'h0, pll_run}, 32'h0);
            check("standby clk sel", {31'h0, clk_sel}, 32'h0);
            deep_idle <= 1'b0;
            stop_mode <= 1'b0;
            tick2();
            settle();
            tick2();
            check("restored clk sel", {31'h0, clk_sel}, 32'h1);
            check("restored run", {31'h0, pll_run}, 32'h1);
            rd(PLLC_ADDR_CONTROL, m_ctrl, "control kept");
        end
        wr(PLLC_ADDR_PCC, 32'h1);
        tick2();
        check("subclock only", {31'h0, unlocked}, 32'h0);
        wr(PLLC_ADDR_PCC, 32'h3);
        wait_flag(1'b1);
        check("subclock flag", {31'h0, cyc <= 3}, 32'h1);
        tick2();
        check("subclock clk sel", {31'h0, clk_sel}, 32'h0);
        rd(PLLC_ADDR_LOCK, m_unl, "lock subclock");
        rd(PLLC_ADDR_PCC, m_pcc, "pcc value");
        wr(PLLC_ADDR_PCC, 32'h0);
        relock("main clock back");
        rd(PLLC_ADDR_CONTROL, m_ctrl, "control after pcc");
        end_of_test();
    end

    task automatic tick2();
        repeat (2) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire
